// [dv/accel_oversample_autosleep_ctrl_tb.sv]
// testbench of the oversampling and auto-sleep control block
`timescale 1ns/1ps
`default_nettype none
`include "accel_params.svh"

module accel_oversample_autosleep_ctrl_tb;
   import accel_pkg::*;
   logic mclk = 1'b0, reset = 1'b1, reg_wr, reg_rd, sleep_request, sample_in, fifo_empty;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
   logic [2:0] active_odr, sleep_odr;
   logic [4:0] func_irq, func_enable;
   logic sample_accept, fifo_flush, gate_error, counter_clear, sleeping;
   logic irq_polarity, irq_drive_type;
   logic [10:0] osr_ratio;
   int error_cnt = 0, n_compared = 0;
   // rows: normal, low-noise, high res, low power; columns: rate code 0..7
   int tbl [4][8] = '{'{2,4,4,4,4,16,32,128}, '{2,4,4,4,4,4,8,32},
                      '{2,4,8,16,32,128,256,1024}, '{2,2,2,2,2,2,4,16}};

   always #10 mclk = ~mclk;

   host_model host (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
                    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

   accel_oversample_autosleep_ctrl uut (.mclk(mclk), .reset(reset), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .active_odr(active_odr), .sleep_odr(sleep_odr), .sleep_request(sleep_request),
      .func_irq(func_irq), .sample_in(sample_in), .fifo_empty(fifo_empty),
      .sample_accept(sample_accept), .fifo_flush(fifo_flush), .gate_error(gate_error),
      .counter_clear(counter_clear), .func_enable(func_enable), .sleeping(sleeping),
      .osr_ratio(osr_ratio), .irq_polarity(irq_polarity), .irq_drive_type(irq_drive_type));

   // ---------------------------------------------
   // checking
   // ---------------------------------------------
   task automatic chk_sig(string nm, logic [10:0] exp, logic [10:0] got);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic chk_reg(string nm, logic [7:0] a, logic [7:0] exp);
      host.rd(a, rv);
      chk_sig(nm, 11'(exp), 11'(rv));
   endtask

   task automatic conclude;
      $display("compared %0d errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic tick(int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   task automatic slp_pulse;
      @(posedge mclk);
      sleep_request <= 1'b1;
      @(posedge mclk);
      sleep_request <= 1'b0;
      #1;
   endtask

   task automatic samp;
      @(posedge mclk);
      sample_in <= 1'b1;
      @(posedge mclk);
      sample_in <= 1'b0;
      #1;
   endtask

   // ---------------------------------------------
   // sequence
   // ---------------------------------------------
   initial begin
      {active_odr, sleep_odr, sleep_request, func_irq} = {3'h0, 3'h5, 1'b0, 5'h00};
      {sample_in, fifo_empty} = 2'b00;
      repeat (6) @(posedge mclk);
      reset <= 1'b0;
      chk_reg("int_wake", 8'h2C, 8'h00);
      chk_reg("power_scheme", 8'h2B, 8'h00);
      chk_reg("unmapped", 8'h3F, 8'h00);
      host.wr(8'h2C, 8'h81);
      tick(1);
      chk_sig("irq_drive_type", 11'(1'b1), 11'(irq_drive_type));
      chk_sig("irq_polarity", 11'(1'b0), 11'(irq_polarity));
      host.wr(8'h2C, 8'h02);
      chk_reg("int_wake", 8'h2C, 8'h02);
      chk_sig("irq_polarity", 11'(1'b1), 11'(irq_polarity));
      host.wr(8'h0B, 8'hFF);
      chk_reg("system_state", 8'h0B, 8'h00);
      for (int m = 0; m < 4; m++)
         for (int o = 0; o < 8; o++) begin
            host.wr(8'h2B, {6'h00, m[1:0]});
            @(posedge mclk);
            active_odr <= o[2:0];
            tick(2);
            chk_sig("osr_ratio", tbl[m][o][10:0], osr_ratio);
         end
      @(posedge mclk);
      active_odr <= 3'h0;
      host.wr(8'h2B, 8'h10);
      @(posedge mclk);
      sleep_request <= 1'b1;
      tick(3);
      chk_sig("sleeping", 11'(1'b0), 11'(sleeping));
      @(posedge mclk);
      sleep_request <= 1'b0;
      host.wr(8'h2C, 8'h0C);
      host.wr(8'h2B, 8'h14);
      slp_pulse();
      chk_sig("sleep_flags", 11'h00F, 11'({sleeping, fifo_flush, counter_clear, 1'b1}));
      chk_sig("func_enable", 11'h01F, 11'(func_enable));
      tick(1);
      chk_sig("fifo_flush", 11'(1'b0), 11'(fifo_flush));
      chk_sig("func_enable", 11'h003, 11'(func_enable));
      chk_sig("osr_ratio", tbl[2][5][10:0], osr_ratio);
      chk_reg("system_state", 8'h0B, 8'h01);
      @(posedge mclk);
      func_irq <= 5'h10;
      @(posedge mclk);
      func_irq <= 5'h02;
      tick(0);
      chk_sig("sleeping", 11'(1'b1), 11'(sleeping));
      @(posedge mclk);
      func_irq <= 5'h00;
      #1;
      chk_sig("wake_flags", 11'h003, 11'({sleeping, fifo_flush, counter_clear}));
      tick(1);
      chk_sig("osr_ratio", tbl[0][0][10:0], osr_ratio);
      host.wr(8'h2C, 8'h8C);
      samp();
      chk_sig("sample_accept", 11'(1'b1), 11'(sample_accept));
      slp_pulse();
      // gated change: counters cleared, buffer kept
      chk_sig("gate_flags", 11'h005, 11'({sleeping, fifo_flush, counter_clear}));
      samp();
      chk_sig("blocked", 11'h001, 11'({sample_accept, gate_error}));
      chk_reg("system_state", 8'h0B, 8'h81);
      @(posedge mclk);
      fifo_empty <= 1'b1;
      tick(2);
      chk_sig("gate_error", 11'(1'b0), 11'(gate_error));
      @(posedge mclk);
      fifo_empty <= 1'b0;
      samp();
      chk_sig("sample_accept", 11'(1'b1), 11'(sample_accept));
      host.wr(8'h2B, 8'h00);
      tick(1);
      chk_sig("sleeping", 11'(1'b0), 11'(sleeping));
      conclude();
   end

   // bounded run, far beyond the few hundred cycles the sequence needs
   initial begin
      repeat (20000) @(posedge mclk);
      error_cnt++;
      conclude();
   end
endmodule // accel_oversample_autosleep_ctrl_tb

`default_nettype wire

// [dv/host_model.sv]
// host side of the register port
`timescale 1ns/1ps
`default_nettype none

module host_model (
   // clock
   input  wire logic       mclk,
   // register port
   output var  logic       reg_wr,
   output var  logic       reg_rd,
   output var  logic [7:0] reg_addr,
   output var  logic [7:0] reg_wdata,
   input  wire logic [7:0] reg_rdata
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end

   // released lines show the inverse so stale values never match
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      #1;
      d = reg_rdata;
   endtask
endmodule // host_model

`default_nettype wire

// [logic/accel_oversample_autosleep_ctrl.sv]
// auto-sleep state, buffer gating and oversampling selection
`timescale 1ns/1ps
`default_nettype none
`include "accel_params.svh"

module accel_oversample_autosleep_ctrl
   import accel_pkg::*;
(
   // clock and reset
   input  wire logic                   mclk,
   input  wire logic                   reset,
   // register port from the serial interface
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   input  wire logic [7:0]             reg_addr,
   input  wire logic [7:0]             reg_wdata,
   output var  logic [7:0]             reg_rdata,
   // data rates and events
   input  wire logic [`ODR_W-1:0]      active_odr,
   input  wire logic [`ODR_W-1:0]      sleep_odr,
   input  wire logic                   sleep_request,
   input  wire logic [`NUM_FUNCS-1:0]  func_irq,
   // sample buffer
   input  wire logic                   sample_in,
   input  wire logic                   fifo_empty,
   output var  logic                   sample_accept,
   output var  logic                   fifo_flush,
   output var  logic                   gate_error,
   // embedded functions
   output var  logic                   counter_clear,
   output var  logic [`NUM_FUNCS-1:0]  func_enable,
   // state and selection
   output var  logic                   sleeping,
   output var  logic [`RATIO_W-1:0]    osr_ratio,
   output var  logic                   irq_polarity,
   output var  logic                   irq_drive_type
);

   // ---------------------------------------------
   // registers
   // ---------------------------------------------
   logic [7:0]                ps_ctrl_q;
   logic [7:0]                iw_ctrl_q;
   logic [7:0]                rdata_q;
   sys_state_t                state_q;
   sys_state_t                state_d;
   logic                      block_q;
   logic                      block_d;
   logic                      gerr_q;
   logic                      gerr_d;
   logic                      flush_q;
   logic                      clr_q;
   logic                      accept_q;
   logic [`NUM_FUNCS-1:0]     fen_q;
   logic [`RATIO_W-1:0]       ratio_q;
   logic                      sleep_q;

   // ---------------------------------------------
   // decode
   // ---------------------------------------------
   wire logic                 wr_ps     = reg_wr && (reg_addr == `OFS_POWER_SCHEME);
   wire logic                 wr_iw     = reg_wr && (reg_addr == `OFS_INT_WAKE_CTRL);
   wire logic                 slpe      = ps_ctrl_q[`PS_SLPE_BIT];
   wire logic                 gate_on   = iw_ctrl_q[`IW_FIFO_GATE_BIT];
   wire logic [`NUM_FUNCS-1:0] wake_en  = iw_ctrl_q[`IW_WAKE_HI:`IW_WAKE_LO];
   wire logic                 wake_hit  = |(func_irq & wake_en);
   wire logic                 trans     = (state_d != state_q);
   wire logic [7:0]           sys_state = {gerr_q, 6'h00, state_q == ST_SLEEP};
   wire logic [7:0]           rd_mux    =
      (reg_addr == `OFS_POWER_SCHEME)  ? ps_ctrl_q :
      (reg_addr == `OFS_INT_WAKE_CTRL) ? iw_ctrl_q :
      (reg_addr == `OFS_SYSTEM_STATE)  ? sys_state : 8'h00;

   // ---------------------------------------------
   // sleep/wake state
   // ---------------------------------------------
   always_comb begin
      state_d = state_q;
      if (!slpe) begin
         state_d = ST_WAKE;
      end else begin
         unique case (state_q)
            ST_WAKE:  if (sleep_request) state_d = ST_SLEEP;
            ST_SLEEP: if (wake_hit) state_d = ST_WAKE;
         endcase
      end
   end

   // a gated change holds off new samples until the host drains the buffer
   assign block_d = (trans && gate_on) || (block_q && !fifo_empty);
   // set wins over the clear by emptying
   assign gerr_d  = (block_q && sample_in) || (gerr_q && !fifo_empty);

   // ---------------------------------------------
   // ratio selection
   // ---------------------------------------------
   osr_if osr_bus ();

   // sleep uses its own scheme field and rate
   assign osr_bus.mode = (state_q == ST_SLEEP) ?
                         osr_mode_t'(ps_ctrl_q[`PS_SMODS_HI:`PS_SMODS_LO]) :
                         osr_mode_t'(ps_ctrl_q[`PS_MODS_HI:`PS_MODS_LO]);
   assign osr_bus.odr  = (state_q == ST_SLEEP) ? sleep_odr : active_odr;

   osr_lookup u_lookup (
      .port_s (osr_bus.table_side)
   );

   // ---------------------------------------------
   // flops
   // ---------------------------------------------
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         ps_ctrl_q <= `RST_POWER_SCHEME;
         iw_ctrl_q <= `RST_INT_WAKE_CTRL;
         rdata_q   <= 8'h00;
      end else begin
         if (wr_ps) ps_ctrl_q <= reg_wdata;
         if (wr_iw) iw_ctrl_q <= reg_wdata;
         if (reg_rd) rdata_q <= rd_mux;
      end
   end

   // status flags of the functions live outside and are never touched here
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         state_q  <= ST_WAKE;
         block_q  <= 1'b0;
         gerr_q   <= 1'b0;
         flush_q  <= 1'b0;
         clr_q    <= 1'b0;
         accept_q <= 1'b0;
         fen_q    <= '1;
         ratio_q  <= 11'h0000;
         sleep_q  <= 1'b0;
      end else begin
         state_q  <= state_d;
         block_q  <= block_d;
         gerr_q   <= gerr_d;
         flush_q  <= trans && !gate_on;
         clr_q    <= trans;
         accept_q <= sample_in && !block_q;
         fen_q    <= (state_q == ST_SLEEP) ? wake_en : '1;
         ratio_q  <= osr_bus.ratio;
         sleep_q  <= (state_d == ST_SLEEP);
      end
   end

   // ---------------------------------------------
   // outputs
   // ---------------------------------------------
   assign reg_rdata      = rdata_q;
   assign sample_accept  = accept_q;
   assign fifo_flush     = flush_q;
   assign gate_error     = gerr_q;
   assign counter_clear  = clr_q;
   assign func_enable    = fen_q;
   assign sleeping       = sleep_q;
   assign osr_ratio      = ratio_q;
   assign irq_polarity   = iw_ctrl_q[`IW_IPOL_BIT];
   assign irq_drive_type = iw_ctrl_q[`IW_DRIVE_BIT];

   // ---------------------------------------------
   // checks
   // ---------------------------------------------
   property p_no_sleep_without_slpe;
      @(posedge mclk) disable iff (reset) !slpe |=> !sleeping;
   endproperty
   a_no_sleep_without_slpe: assert property (p_no_sleep_without_slpe)
      else $error("sleep entered with auto-sleep off");

   property p_flush_on_change;
      @(posedge mclk) disable iff (reset)
         // a second change right behind the first pulses the flush again
         (trans && !gate_on) ##1 !trans |-> (fifo_flush && counter_clear) ##1 !fifo_flush;
   endproperty
   a_flush_on_change: assert property (p_flush_on_change)
      else $error("no flush and clear after state change");

   property p_clear_only_on_change;
      @(posedge mclk) disable iff (reset) counter_clear |-> (sleeping != $past(sleeping));
   endproperty
   a_clear_only_on_change: assert property (p_clear_only_on_change)
      else $error("counter clear without a state change");

   property p_gate_blocks;
      @(posedge mclk) disable iff (reset)
         (trans && gate_on && !fifo_empty) |=> !fifo_flush ##1 !sample_accept;
   endproperty
   a_gate_blocks: assert property (p_gate_blocks)
      else $error("gated change did not hold the buffer");

   property p_gate_error;
      @(posedge mclk) disable iff (reset)
         (block_q && sample_in) |=> gate_error ##1 (gate_error || $past(fifo_empty));
   endproperty
   a_gate_error: assert property (p_gate_error)
      else $error("gate error not raised or dropped early");

   property p_sleep_enables;
      @(posedge mclk) disable iff (reset)
         (sleeping && $stable(iw_ctrl_q)) |=> func_enable == $past(wake_en);
   endproperty
   a_sleep_enables: assert property (p_sleep_enables)
      else $error("sleep function enables differ from wake enables");

   property p_reg3_reset;
      @(posedge mclk) $fell(reset) |-> (iw_ctrl_q == 8'h00);
   endproperty
   a_reg3_reset: assert property (p_reg3_reset)
      else $error("interrupt/wake control not zero after reset");

   property p_hires_slowest;
      @(posedge mclk) disable iff (reset)
         (!sleeping && ps_ctrl_q[1:0] == 2'h2 && active_odr == 3'h7) |=> osr_ratio == 11'h0400;
   endproperty
   a_hires_slowest: assert property (p_hires_slowest)
      else $error("high resolution ratio wrong at lowest rate");

   property p_sleep_ratio;
      @(posedge mclk) disable iff (reset)
         (sleeping && ps_ctrl_q[4:3] == 2'h3 && sleep_odr == 3'h7) |=> osr_ratio == 11'h0010;
   endproperty
   a_sleep_ratio: assert property (p_sleep_ratio)
      else $error("sleep ratio not from sleep scheme");

endmodule // accel_oversample_autosleep_ctrl

`default_nettype wire

// [logic/accel_params.svh]
// constants of the oversampling and auto-sleep control block
`ifndef ACCEL_PARAMS_SVH
`define ACCEL_PARAMS_SVH

// ---------------------------------------------
// register offsets
// ---------------------------------------------
`define OFS_SYSTEM_STATE      8'h0B
`define OFS_POWER_SCHEME      8'h2B
`define OFS_INT_WAKE_CTRL     8'h2C

// ---------------------------------------------
// reset values
// ---------------------------------------------
`define RST_POWER_SCHEME      8'h00
`define RST_INT_WAKE_CTRL     8'h00

// ---------------------------------------------
// power_scheme_control fields
// ---------------------------------------------
`define PS_SMODS_HI           4
`define PS_SMODS_LO           3
`define PS_SLPE_BIT           2
`define PS_MODS_HI            1
`define PS_MODS_LO            0

// ---------------------------------------------
// interrupt_wake_control fields
// ---------------------------------------------
`define IW_FIFO_GATE_BIT      7
`define IW_WAKE_HI            6
`define IW_WAKE_LO            2
`define IW_IPOL_BIT           1
`define IW_DRIVE_BIT          0

// ---------------------------------------------
// system_state_reg fields
// ---------------------------------------------
`define SS_GATE_ERR_BIT       7
`define SS_SLEEP_BIT          0

// ---------------------------------------------
// sizes
// ---------------------------------------------
`define NUM_FUNCS             5
`define RATIO_W               11
`define ODR_W                 3

`endif

// [logic/accel_pkg.sv]
// types of the oversampling and auto-sleep control block
package accel_pkg;

   // oversampling scheme, same encoding for active and sleep
   typedef enum logic [1:0] {
      OSM_NORMAL  = 2'h0,
      OSM_LNLP    = 2'h1,
      OSM_HIRES   = 2'h2,
      OSM_LOWPWR  = 2'h3
   } osr_mode_t;

   typedef enum logic {
      ST_WAKE,
      ST_SLEEP
   } sys_state_t;

endpackage

// [logic/osr_if.sv]
// carrier between the controller and the ratio lookup
`timescale 1ns/1ps
`default_nettype none
`include "accel_params.svh"

interface osr_if;
   import accel_pkg::*;
   osr_mode_t                 mode;
   logic [`ODR_W-1:0]         odr;
   logic [`RATIO_W-1:0]       ratio;

   modport ctrl (output mode, output odr, input ratio);
   modport table_side (input mode, input odr, output ratio);
endinterface

`default_nettype wire

// [logic/osr_lookup.sv]
// oversampling ratio lookup from scheme code and data rate code
`timescale 1ns/1ps
`default_nettype none
`include "accel_params.svh"

module osr_lookup
   import accel_pkg::*;
(
   // scheme and rate in, ratio out
   osr_if.table_side          port_s
);

   // odr code: 0=800 1=400 2=200 3=100 4=50 5=12.5 6=6.25 7=1.5625 Hz
   function automatic logic [`RATIO_W-1:0] ratio_of(input osr_mode_t m,
                                                    input logic [`ODR_W-1:0] r);
      logic [`RATIO_W-1:0] v;
      v = 11'h0002;
      unique case (m)
         OSM_NORMAL: begin
            unique case (r)
               3'h0:    v = 11'h0002;
               3'h5:    v = 11'h0010;
               3'h6:    v = 11'h0020;
               3'h7:    v = 11'h0080;
               default: v = 11'h0004;
            endcase
         end
         OSM_LNLP: begin
            unique case (r)
               3'h0:    v = 11'h0002;
               3'h6:    v = 11'h0008;
               3'h7:    v = 11'h0020;
               default: v = 11'h0004;
            endcase
         end
         OSM_HIRES: begin
            unique case (r)
               3'h0:    v = 11'h0002;
               3'h1:    v = 11'h0004;
               3'h2:    v = 11'h0008;
               3'h3:    v = 11'h0010;
               3'h4:    v = 11'h0020;
               3'h5:    v = 11'h0080;
               3'h6:    v = 11'h0100;
               3'h7:    v = 11'h0400;
            endcase
         end
         OSM_LOWPWR: begin
            unique case (r)
               3'h6:    v = 11'h0004;
               3'h7:    v = 11'h0010;
               default: v = 11'h0002;
            endcase
         end
      endcase
      return v;
   endfunction

   // one table serves both states, the caller picks the inputs
   assign port_s.ratio = ratio_of(port_s.mode, port_s.odr);

endmodule // osr_lookup

`default_nettype wire
